// ==== design/btc_trace_ctrl.sv ====
// bus trace capture control with AXI4-Lite register slave
// What this block does
// - after a selected delayed-stop event, store for the programmed 1..65535 more bus cycles, then halt.
// - immediate stop and delayed stop may be armed together and act independently.
// - delayed-stop event selections do nothing while the delayed-stop enable is clear.
// - range channels work only with free-running trace off; otherwise only halting applies.
// - four range channels, each disabled, point-to-point, range filter or start/stop event.
// - a disabled channel has no say in which cycles are stored.
// - point-to-point stores from an access to the start address to an access to the stop address.
// - with cyclic set a channel re-arms after its stop event; without it the channel stays stopped.
// - range filter stores only cycles meeting the selected event.
// - event mode stores from the start event to the stop event.
// - a record holds address, data, kind, area, status, four probes, eight interrupt inputs.
// - with time stamping on, a time stamp replaces area, status, probe and interrupt fields.
// - free-running trace stores from the start of program execution with no start event.
// - the time stamp is a wrapping 32-bit counter ticking at 125 ns to 100 us.
`include "btc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module btc_trace_ctrl
  import btc_pkg::*;
#(
  parameter int unsigned TS_MAX_NS = `BTC_TS_MAX_NS
) (
  input  wire logic        mclk,          // bus cycle clock
  input  wire logic        nrst,          // async reset, active low
  input  wire logic [7:0]  s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write byte enables
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [7:0]  s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  input  wire logic        exec_start,    // program execution begins, pulse
  input  wire logic        bus_valid,     // one observed bus cycle
  input  wire logic [31:0] bus_addr,      // cycle address
  input  wire logic [31:0] bus_data,      // cycle data
  input  wire logic        bus_rw,        // 1 read, 0 write
  input  wire logic [3:0]  bus_area,      // accessed area
  input  wire logic [3:0]  bus_status,    // bus status code
  input  wire logic [15:0] events,        // event comparator hits
  input  wire logic [3:0]  probe_pins,    // probe pins, async
  input  wire logic [7:0]  external_interrupt_inputs, // async pins
  output logic             rec_valid,     // record write strobe
  output logic [31:0]      rec_addr,      // record address
  output logic [31:0]      rec_data,      // record data
  output logic             rec_rw,        // record kind
  output logic [31:0]      rec_aux,       // side fields or time stamp
  output logic             rec_is_ts,     // rec_aux holds a time stamp
  output logic             trace_halted   // acquisition halted
);
  logic [31:0] ctrl_q, stop_sel_q, dst_sel_q, delay_q;
  logic [31:0] cfg_q [`BTC_NCH];
  logic [31:0] sta_q [`BTC_NCH];
  logic [31:0] sto_q [`BTC_NCH];
  logic        aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [7:0]  waddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [3:0]  probe_s1_q, probe_s2_q;
  logic [7:0]  irq_s1_q, irq_s2_q;
  logic        acq_q, halted_q, dly_act_q;
  logic [15:0] dly_cnt_q;
  logic [31:0] ts_q, pre_q;

  // AXI write path: address and data taken in either order
  assign s_axi_awready = ~aw_have_q & ~bvalid_q;
  assign s_axi_wready  = ~w_have_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  wire       wr_fire = aw_have_q & w_have_q;
  wire       rd_fire = s_axi_arvalid & ~rvalid_q;
  wire [3:0] w_reg   = waddr_q[7:4];
  wire [1:0] w_ch    = waddr_q[3:2];
  wire       w_chreg = (w_reg >= `BTC_R_CHCFG) && (w_reg <= `BTC_R_CHSTO);
  wire       w_base  = (waddr_q == `BTC_A_CTRL) || (waddr_q == `BTC_A_STOPSEL) ||
                       (waddr_q == `BTC_A_DSTSEL) || (waddr_q == `BTC_A_DELAY);
  wire       w_ok    = w_base | w_chreg | (waddr_q == `BTC_A_STATUS) |
                       (waddr_q == `BTC_A_TSTAMP);
  wire       wr_ctrl = wr_fire & (waddr_q == `BTC_A_CTRL);
  // start bit is a self-clearing pulse, not stored
  wire       sw_start = wr_ctrl & wstrb_q[1] & wdata_q[`BTC_C_START];
  wire       start   = sw_start | exec_start;

  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n,
                                      input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction : mrg

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `BTC_RESP_OK;
      waddr_q   <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        waddr_q   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= w_ok ? `BTC_RESP_OK : `BTC_RESP_ERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q     <= 32'h0000_0000;
      stop_sel_q <= 32'h0000_0000;
      dst_sel_q  <= 32'h0000_0000;
      delay_q    <= 32'h0000_0001;
    end else if (wr_fire) begin
      if (waddr_q == `BTC_A_CTRL)
        ctrl_q <= mrg(ctrl_q, wdata_q, wstrb_q) & `BTC_CTRL_MASK;
      if (waddr_q == `BTC_A_STOPSEL)
        stop_sel_q <= mrg(stop_sel_q, wdata_q, wstrb_q) & 32'h0000_FFFF;
      if (waddr_q == `BTC_A_DSTSEL)
        dst_sel_q <= mrg(dst_sel_q, wdata_q, wstrb_q) & 32'h0000_FFFF;
      if (waddr_q == `BTC_A_DELAY)
        delay_q <= mrg(delay_q, wdata_q, wstrb_q) & 32'h0000_FFFF;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `BTC_NCH; i++) begin
        cfg_q[i] <= 32'h0000_0000;
        sta_q[i] <= 32'h0000_0000;
        sto_q[i] <= 32'h0000_0000;
      end
    end else if (wr_fire && w_chreg) begin
      if (w_reg == `BTC_R_CHCFG)
        cfg_q[w_ch] <= mrg(cfg_q[w_ch], wdata_q, wstrb_q) & 32'h0000_0FF7;
      if (w_reg == `BTC_R_CHSTA)
        sta_q[w_ch] <= mrg(sta_q[w_ch], wdata_q, wstrb_q);
      if (w_reg == `BTC_R_CHSTO)
        sto_q[w_ch] <= mrg(sto_q[w_ch], wdata_q, wstrb_q);
    end
  end

  // read path, answer one cycle after the address is taken
  wire [3:0]  r_reg   = s_axi_araddr[7:4];
  wire [1:0]  r_ch    = s_axi_araddr[3:2];
  wire [31:0] status  = {dly_cnt_q, 13'h0000, dly_act_q, halted_q, acq_q};
  logic [31:0] rd_word;
  logic        rd_ok;
  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      `BTC_A_CTRL:    rd_word = ctrl_q;
      `BTC_A_STOPSEL: rd_word = stop_sel_q;
      `BTC_A_DSTSEL:  rd_word = dst_sel_q;
      `BTC_A_DELAY:   rd_word = delay_q;
      `BTC_A_STATUS:  rd_word = status;
      `BTC_A_TSTAMP:  rd_word = ts_q;
      default: begin
        case (r_reg)
          `BTC_R_CHCFG: rd_word = cfg_q[r_ch];
          `BTC_R_CHSTA: rd_word = sta_q[r_ch];
          `BTC_R_CHSTO: rd_word = sto_q[r_ch];
          default:      rd_ok = 1'b0;
        endcase
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `BTC_RESP_OK;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_ok ? `BTC_RESP_OK : `BTC_RESP_ERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // probes and interrupt lines are asynchronous pins
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      probe_s1_q <= 4'h0;
      probe_s2_q <= 4'h0;
      irq_s1_q   <= 8'h00;
      irq_s2_q   <= 8'h00;
    end else begin
      probe_s1_q <= probe_pins;
      probe_s2_q <= probe_s1_q;
      irq_s1_q   <= external_interrupt_inputs;
      irq_s2_q   <= irq_s1_q;
    end
  end

  wire free_run = ctrl_q[`BTC_C_FREE];
  wire ts_en    = ctrl_q[`BTC_C_TSEN];
  wire [`BTC_NCH-1:0] ch_en, ch_store;

  for (genvar g = 0; g < `BTC_NCH; g++) begin : g_ch
    btc_mode_t mode;
    btc_chst_t st_q, st_d;
    assign mode = btc_mode_t'(cfg_q[g][1:0]);
    wire       cyc  = cfg_q[g][2];
    wire [3:0] ssel = cfg_q[g][7:4];
    wire [3:0] psel = cfg_q[g][11:8];
    // point-to-point compares addresses, event mode uses events
    wire s_hit = (mode == BTC_M_P2P) ? (bus_addr == sta_q[g]) : events[ssel];
    wire p_hit = (mode == BTC_M_P2P) ? (bus_addr == sto_q[g]) : events[psel];
    wire win   = (st_q == BTC_S_ACTIVE) | ((st_q == BTC_S_ARMED) & s_hit);
    // disabled channel drops out of the vote
    assign ch_en[g] = (mode != BTC_M_OFF);
    // range filter stores matching cycles only
    assign ch_store[g] = (mode == BTC_M_RANGE) ? events[ssel] :
                         (ch_en[g] & win);
    always_comb begin
      st_d = st_q;
      case (st_q)
        BTC_S_ARMED:  if (s_hit) st_d = p_hit ? (cyc ? BTC_S_ARMED : BTC_S_DONE)
                                              : BTC_S_ACTIVE;
        // cyclic re-arms after the stop event
        BTC_S_ACTIVE: if (p_hit) st_d = cyc ? BTC_S_ARMED : BTC_S_DONE;
        BTC_S_DONE:   st_d = BTC_S_DONE;
        default:      st_d = BTC_S_ARMED;
      endcase
    end
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
        st_q <= BTC_S_ARMED;
      else if (start)
        st_q <= BTC_S_ARMED;
      else if (bus_valid && acq_q && !free_run && mode != BTC_M_RANGE)
        st_q <= st_d;
    end
  end

  // free-running stores everything; no enabled channel also stores all
  wire win_ok = free_run | ~(|ch_en) | (|ch_store);
  wire take   = bus_valid & acq_q;
  wire store  = take & win_ok;
  // both stop paths evaluated side by side
  wire imm_hit = ctrl_q[`BTC_C_STOP] & (|(events & stop_sel_q[15:0]));
  // delayed selections gated by their enable
  wire dly_hit = ctrl_q[`BTC_C_DSTOP] & (|(events & dst_sel_q[15:0]));
  wire dly_end = dly_act_q & (dly_cnt_q == 16'h0001);
  wire halt    = take & (imm_hit | dly_end);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      acq_q     <= 1'b0;
      halted_q  <= 1'b0;
      dly_act_q <= 1'b0;
      dly_cnt_q <= 16'h0000;
    end else if (start) begin
      acq_q     <= 1'b1;
      halted_q  <= 1'b0;
      dly_act_q <= 1'b0;
    end else if (halt) begin
      acq_q     <= 1'b0;
      halted_q  <= 1'b1;
      dly_act_q <= 1'b0;
    end else if (take && dly_act_q) begin
      // count bus cycles, no reload while running
      dly_cnt_q <= dly_cnt_q - 16'h0001;
    end else if (take && dly_hit) begin
      // load delay, zero treated as one
      dly_act_q <= 1'b1;
      dly_cnt_q <= (delay_q[15:0] == 16'h0000) ? 16'h0001 : delay_q[15:0];
    end
  end

  function automatic logic [31:0] ts_cyc(input logic [3:0] s);
    int unsigned n;
    case (s)
      4'h0:    n = `BTC_TS_R0;
      4'h1:    n = `BTC_TS_R1;
      4'h2:    n = `BTC_TS_R2;
      4'h3:    n = `BTC_TS_R3;
      4'h4:    n = `BTC_TS_R4;
      4'h5:    n = `BTC_TS_R5;
      4'h6:    n = `BTC_TS_R6;
      4'h7:    n = `BTC_TS_R7;
      default: n = TS_MAX_NS;
    endcase
    // period rounds down to whole cycles, never below one
    n = n / `BTC_CLK_NS;
    return (n == 0) ? 32'h0000_0001 : n;
  endfunction : ts_cyc

  wire [31:0] ts_per = ts_cyc(ctrl_q[`BTC_C_TSL +: 4]);
  wire        ts_tick = (pre_q >= ts_per - 32'h0000_0001);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pre_q <= 32'h0000_0000;
      ts_q  <= 32'h0000_0000;
    end else if (start || !ts_en) begin
      pre_q <= 32'h0000_0000;
      ts_q  <= 32'h0000_0000;
    end else begin
      pre_q <= ts_tick ? 32'h0000_0000 : pre_q + 32'h0000_0001;
      // wraps to zero and keeps counting
      if (ts_tick)
        ts_q <= ts_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rec_valid <= 1'b0;
      rec_addr  <= 32'h0000_0000;
      rec_data  <= 32'h0000_0000;
      rec_rw    <= 1'b0;
      rec_aux   <= 32'h0000_0000;
      rec_is_ts <= 1'b0;
    end else begin
      rec_valid <= store;
      if (store) begin
        rec_addr  <= bus_addr;
        rec_data  <= bus_data;
        rec_rw    <= bus_rw;
        rec_is_ts <= ts_en;
        // time stamp takes the side fields' place
        rec_aux   <= ts_en ? ts_q :
                     {12'h000, irq_s2_q, probe_s2_q, bus_status, bus_area};
      end
    end
  end

  assign trace_halted = halted_q;
endmodule : btc_trace_ctrl
`default_nettype wire

// ==== include/btc_consts.svh ====
// constants for the bus trace capture control block
`ifndef BTC_CONSTS_SVH
`define BTC_CONSTS_SVH
`define BTC_CLK_NS    10
`define BTC_NCH       4
`define BTC_NEV       16
`define BTC_A_CTRL    8'h00
`define BTC_A_STOPSEL 8'h04
`define BTC_A_DSTSEL  8'h08
`define BTC_A_DELAY   8'h0C
`define BTC_A_STATUS  8'h40
`define BTC_A_TSTAMP  8'h44
`define BTC_R_CHCFG   4'h1
`define BTC_R_CHSTA   4'h2
`define BTC_R_CHSTO   4'h3
`define BTC_C_FREE    0
`define BTC_C_STOP    1
`define BTC_C_DSTOP   2
`define BTC_C_TSEN    3
`define BTC_C_TSL     4
`define BTC_C_START   8
`define BTC_CTRL_MASK 32'h0000_00FF
`define BTC_TS_R0     125
`define BTC_TS_R1     250
`define BTC_TS_R2     500
`define BTC_TS_R3     1000
`define BTC_TS_R4     2000
`define BTC_TS_R5     4000
`define BTC_TS_R6     8000
`define BTC_TS_R7     16000
`define BTC_TS_MAX_NS 100000
`define BTC_RESP_OK   2'b00
`define BTC_RESP_ERR  2'b10
`endif

// ==== include/btc_pkg.sv ====
// types for the bus trace capture control block
package btc_pkg;
  typedef enum logic [1:0] {
    BTC_M_OFF   = 2'b00,
    BTC_M_P2P   = 2'b01,
    BTC_M_RANGE = 2'b10,
    BTC_M_EVENT = 2'b11
  } btc_mode_t;
  typedef enum logic [2:0] {
    BTC_S_ARMED  = 3'b001,
    BTC_S_ACTIVE = 3'b010,
    BTC_S_DONE   = 3'b100
  } btc_chst_t;
endpackage : btc_pkg

// ==== testbench/btc_bus_model.sv ====
// target bus model: numbered bus cycles, each hitting one event
`timescale 1ns/1ps
`default_nettype none
module btc_bus_model (
  input  wire logic       mclk,       // clock
  input  wire logic       nrst,       // reset, active low
  input  wire logic       exec_start, // restart numbering
  input  wire logic [7:0] len,        // cycles per run
  input  wire logic [1:0] gap,        // idle cycles between
  output logic            bus_valid,  // cycle strobe
  output logic [31:0]     bus_addr,   // address
  output logic [31:0]     bus_data,   // data
  output logic            bus_rw,     // 1 read
  output logic [3:0]      bus_area,   // area
  output logic [3:0]      bus_status, // status
  output logic [15:0]     events      // comparator hits
);
  logic [7:0] n_q;
  logic [1:0] w_q;
  logic       on_q;
  // idle lines show the inverse, and events show zero, so a stale value never passes
  assign bus_valid  = on_q && (w_q == 2'b00);
  assign bus_addr   = {22'h00_0000, n_q, 2'b00} ^ {32{~bus_valid}};
  assign bus_data   = ~bus_addr;
  assign bus_rw     = n_q[0] ^ ~bus_valid;
  assign bus_area   = bus_addr[5:2];
  assign bus_status = ~bus_area;
  assign events     = bus_valid ? (16'h0001 << n_q[3:0]) : 16'h0000;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      on_q <= 1'b0;
      n_q  <= 8'h00;
      w_q  <= 2'b00;
    end else if (exec_start) begin
      on_q <= 1'b1;
      n_q  <= 8'h00;
      w_q  <= 2'b00;
    end else if (on_q) begin
      w_q <= (w_q == gap) ? 2'b00 : w_q + 2'd1;
      if (bus_valid) begin
        n_q  <= n_q + 8'd1;
        on_q <= (n_q + 8'd1 != len);
      end
    end
  end
endmodule : btc_bus_model
`default_nettype wire

// ==== testbench/btc_trace_ctrl_asserts.sv ====
// port checker for the trace capture control
`timescale 1ns/1ps
`default_nettype none
module btc_tc_chk (
  input wire logic        mclk,          // clock
  input wire logic        nrst,          // reset, active low
  input wire logic        s_axi_awvalid, // aw valid
  input wire logic        s_axi_awready, // aw ready
  input wire logic        s_axi_wvalid,  // w valid
  input wire logic        s_axi_wready,  // w ready
  input wire logic        s_axi_bvalid,  // b valid
  input wire logic        exec_start,    // start pulse
  input wire logic        bus_valid,     // bus cycle
  input wire logic [31:0] bus_addr,      // cycle address
  input wire logic [3:0]  bus_area,      // cycle area
  input wire logic [3:0]  bus_status,    // cycle status
  input wire logic        rec_valid,     // record strobe
  input wire logic [31:0] rec_addr,      // record address
  input wire logic [31:0] rec_aux,       // side fields
  input wire logic        rec_is_ts,     // time stamp record
  input wire logic        trace_halted   // halted
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  rec_cause_a: assert property (rec_valid |-> $past(bus_valid))
    else $error("record without bus cycle");
  rec_addr_a: assert property (rec_valid |-> rec_addr == $past(bus_addr))
    else $error("record address wrong");
  rec_side_a: assert property (rec_valid && !rec_is_ts |->
    rec_aux[7:0] == {$past(bus_status), $past(bus_area)} && rec_aux[31:20] == 12'h000)
    else $error("record side fields wrong");
  halt_hold_a: assert property (trace_halted && !exec_start |=> trace_halted || s_axi_bvalid)
    else $error("halt dropped without start");
  halt_quiet_a: assert property (trace_halted && !exec_start |=> !rec_valid || s_axi_bvalid)
    else $error("record while halted");
  start_clr_a: assert property (exec_start |=> !trace_halted)
    else $error("start left halt set");
  halt_rise_a: assert property ($rose(trace_halted) |-> rec_valid || $past(rec_valid))
    else $error("halt without last record");
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid)
    else $error("write response late");
  cover property (rec_valid && rec_is_ts);
  cover property ($rose(trace_halted));
  cover property (rec_valid ##1 rec_valid);
endmodule : btc_tc_chk
bind btc_trace_ctrl btc_tc_chk u_btc_tc_chk (.*);
`default_nettype wire

// ==== testbench/tb_bus_trace_capture_control.sv ====
// testbench for the trace capture control
`timescale 1ns/1ps
`default_nettype none
module tb_bus_trace_capture_control;
  logic        mclk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, exec_start, bus_valid, bus_rw, rec_valid, rec_rw;
  logic        rec_is_ts, trace_halted;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, external_interrupt_inputs, len;
  logic [31:0] s_axi_wdata, s_axi_rdata, bus_addr, bus_data, rec_addr, rec_data, rec_aux;
  logic [3:0]  s_axi_wstrb, bus_area, bus_status, probe_pins;
  logic [1:0]  s_axi_bresp, s_axi_rresp, gap, wresp;
  logic [15:0] events;
  int          bad_count = 0, checks = 0, recs = 0, cyc = 0;
  // short top time stamp step for settings 8 to 15; the run itself uses the 125 ns step
  btc_trace_ctrl #(.TS_MAX_NS(100)) u_btc_trace_ctrl (.*);
  btc_bus_model u_btc_bus_model (.*);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (rec_valid === 1'b1) recs++;
    if (cyc == 6000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // each item is released at the rising edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic b_t;
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      b_t   = s_axi_bvalid;
      wresp = s_axi_bresp;
    end while (!b_t);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic v;
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
    end while (!v);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check(d, e);
    check(32'(r), 32'(er));
  endtask : rc
  // config, 32 numbered bus cycles, then the record count
  task automatic sc(input logic [11:0] c, input logic [15:0] ss, input logic [15:0] ds,
                    input logic [15:0] dl, input logic [11:0] c0, input logic [11:0] ck,
                    input int k, input logic [1:0] g, input logic [7:0] e);
    int r0;
    wr(8'h00, 32'(c));
    wr(8'h04, 32'(ss));
    wr(8'h08, 32'(ds));
    wr(8'h0C, 32'(dl));
    wr(8'h10, 32'(c0));
    for (int i = 1; i < 4; i++) wr(8'h10 + 8'(i * 4), (i == k) ? 32'(ck) : 32'h0000_0000);
    @(posedge mclk);
    exec_start <= 1'b1;
    len        <= 8'h20;
    gap        <= g;
    r0         = recs;
    @(posedge mclk);
    exec_start <= 1'b0;
    repeat (32 * (g + 1) + 6) @(posedge mclk);
    check(32'(recs - r0), 32'(e));
  endtask : sc
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {exec_start, s_axi_awaddr, s_axi_araddr, s_axi_wdata, len, gap} = '0;
    s_axi_wstrb               = 4'hF;
    probe_pins                = 4'hA;
    external_interrupt_inputs = 8'h5C;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    rc(8'h0C, 32'h0000_0001, 2'b00);
    rc(8'h48, 32'h0000_0000, 2'b10);
    wr(8'h20, 32'h0000_0004);
    wr(8'h30, 32'h0000_0010);
    check(32'(wresp), 32'h0000_0000);
    wr(8'h48, 32'h0000_0000);
    check(32'(wresp), 32'h0000_0002);
    sc(12'h001, 16'h0000, 16'h0000, 16'h0001, 12'h000, 12'h000, 0, 2'd2, 8'h20);
    check(rec_addr, 32'h0000_007C);
    check(rec_data, 32'hFFFF_FF83);
    check(rec_aux, 32'h0005_CA0F);
    check(32'(rec_rw), 32'h0000_0001);
    sc(12'h003, 16'h0020, 16'h0000, 16'h0001, 12'h000, 12'h000, 0, 2'd0, 8'h06);
    rd(8'h40, d, r);
    check({30'h0, d[1], trace_halted}, 32'h0000_0003);
    wr(8'h00, 32'h0000_0100);
    rc(8'h40, 32'h0000_0001, 2'b00);
    rc(8'h00, 32'h0000_0000, 2'b00);
    sc(12'h005, 16'h0000, 16'h000C, 16'h0003, 12'h000, 12'h000, 0, 2'd1, 8'h06);
    sc(12'h005, 16'h0000, 16'h0004, 16'h0001, 12'h000, 12'h000, 0, 2'd0, 8'h04);
    sc(12'h007, 16'h0010, 16'h0004, 16'h0003, 12'h000, 12'h000, 0, 2'd0, 8'h05);
    sc(12'h001, 16'h0020, 16'h0004, 16'h0003, 12'h000, 12'h000, 0, 2'd0, 8'h20);
    sc(12'h000, 16'h0000, 16'h0000, 16'h0001, 12'h523, 12'h000, 0, 2'd0, 8'h04);
    sc(12'h000, 16'h0000, 16'h0000, 16'h0001, 12'h000, 12'h527, 2, 2'd0, 8'h08);
    sc(12'h000, 16'h0000, 16'h0000, 16'h0001, 12'h032, 12'h000, 0, 2'd0, 8'h02);
    sc(12'h000, 16'h0000, 16'h0000, 16'h0001, 12'h001, 12'h000, 0, 2'd0, 8'h04);
    sc(12'h000, 16'h0000, 16'h0000, 16'h0001, 12'h030, 12'h523, 1, 2'd0, 8'h04);
    sc(12'h000, 16'h0000, 16'h0000, 16'h0001, 12'h000, 12'h032, 3, 2'd0, 8'h02);
    sc(12'h001, 16'h0000, 16'h0000, 16'h0001, 12'h032, 12'h000, 0, 2'd0, 8'h20);
    sc(12'h009, 16'h0000, 16'h0000, 16'h0001, 12'h000, 12'h000, 0, 2'd0, 8'h20);
    check(32'(rec_is_ts), 32'h0000_0001);
    check(rec_aux, 32'h0000_0002);
    rd(8'h44, d, r);
    check(32'(d != 32'h0000_0000), 32'h0000_0001);
    test_done();
  end
endmodule : tb_bus_trace_capture_control
`default_nettype wire
